// File: hw/fabric_logic_element.sv
// How it works
// - each lookup table returns its 16-bit mask indexed by its four inputs.
// - the sum output is the table result xor the incoming carry.
// - sum and table output are both driven at all times side by side.
// - carries run through three-bit look-ahead segments chained together.
// - the storage data may come from a direct input, bypassing the table.
// - each storage element is a register or, by configuration, a latch.
// - a storage element takes new data only while its enable is high; asynchronous load ignores the enable.
// - asynchronous load forces the configured value at once.
// - synchronous load stores the configured value at the next edge.
// - configuration picks direct input or table output as storage data.
// - twelve logic elements and twelve interface elements form clusters.
// - interface elements work like logic elements but have no carry.
// - the pad output may be a registered copy, aligning all bus bits.
// - the pad output enable may be taken from its own register.
// - pad inputs are synchronised by two flops, optionally one more.
`default_nettype none
module fabric_logic_element
  import fle_pkg::*;
#(
  parameter int N_LE = LE_PER_CLUSTER,
  parameter int N_IE = IE_PER_CLUSTER,
  parameter int IO_W = IO_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LUT_INPUTS*N_LE-1:0] le_in,
  input wire logic [N_LE-1:0] le_direct_in,
  input wire logic [N_LE-1:0] le_ce,
  input wire logic [N_LE-1:0] le_async_preload,
  input wire logic [N_LE-1:0] le_clocked_preload,
  input wire logic le_cin,
  output logic le_cout,
  output logic [N_LE-1:0] le_y,
  output logic [N_LE-1:0] le_sum,
  output logic [N_LE-1:0] le_q,
  input wire logic [LUT_INPUTS*N_IE-1:0] ie_in,
  input wire logic [N_IE-1:0] ie_direct_in,
  input wire logic [N_IE-1:0] ie_ce,
  input wire logic [N_IE-1:0] ie_async_preload,
  input wire logic [N_IE-1:0] ie_clocked_preload,
  output logic [N_IE-1:0] ie_y,
  output logic [N_IE-1:0] ie_q,
  input wire logic [IO_W-1:0] io_out_data,
  input wire logic [IO_W-1:0] io_oe_data,
  output logic [IO_W-1:0] io_in_data,
  input wire logic [IO_W-1:0] pad_in,
  output logic [IO_W-1:0] pad_out,
  output logic [IO_W-1:0] pad_oe
);
  localparam int N_TOT = N_LE + N_IE;
  localparam int SW = $clog2(N_TOT);
  localparam int N_SEG = N_LE / CARRY_SEG;

  // ****************
  // configuration store
  // ****************
  logic [SW-1:0] sel_q;
  logic [LUT_BITS-1:0] lut_q [N_TOT];
  logic [CFG_BITS-1:0] cfg_q [N_TOT];
  logic [2:0] io_cfg_q;
  logic ready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic wr_en;
  logic sel_ok;
  logic [31:0] rd_d;
  logic rd_err;

  // ****************
  // element arrays
  // ****************
  logic [LUT_INPUTS*N_TOT-1:0] all_in;
  logic [N_TOT-1:0] all_direct;
  logic [N_TOT-1:0] all_ce;
  logic [N_TOT-1:0] all_aload;
  logic [N_TOT-1:0] all_sload;
  logic [N_TOT-1:0] all_y;
  logic [N_TOT-1:0] all_q;
  logic [N_LE:0] carry;
  logic [N_LE-1:0] gen;

  assign all_in = {ie_in, le_in};
  assign all_direct = {ie_direct_in, le_direct_in};
  assign all_ce = {ie_ce, le_ce};
  assign all_aload = {ie_async_preload, le_async_preload};
  assign all_sload = {ie_clocked_preload, le_clocked_preload};
  assign le_y = all_y[N_LE-1:0];
  assign ie_y = all_y[N_TOT-1:N_LE];
  assign le_q = all_q[N_LE-1:0];
  assign ie_q = all_q[N_TOT-1:N_LE];

  // ****************
  // apb slave
  // ****************
  // ready_q is set by a setup edge with the clock enabled, so prdata
  // is always captured before the access phase can complete
  assign pready = psel && penable && ready_q && clk_en;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign wr_en = pready && pwrite;
  assign sel_ok = sel_q < SW'(N_TOT);

  always_comb begin
    rd_d = 32'h00000000;
    rd_err = 1'b0;
    unique case (paddr)
      OFF_SEL: rd_d[SW-1:0] = sel_q;
      OFF_LUT: begin
        rd_err = !sel_ok;
        if (sel_ok) begin
          rd_d[LUT_BITS-1:0] = lut_q[sel_q];
        end
      end
      OFF_CFG: begin
        rd_err = !sel_ok;
        if (sel_ok) begin
          rd_d[CFG_BITS-1:0] = cfg_q[sel_q];
        end
      end
      OFF_LE_Q: rd_d[N_LE-1:0] = le_q;
      OFF_IE_Q: rd_d[N_IE-1:0] = ie_q;
      OFF_IO_CFG: rd_d[2:0] = io_cfg_q;
      OFF_IO_IN: rd_d[IO_W-1:0] = io_in_data;
      default: rd_err = 1'b1;
    endcase
    if (pwrite && (paddr == OFF_LE_Q || paddr == OFF_IE_Q ||
        paddr == OFF_IO_IN)) begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      if (pready) begin
        ready_q <= 1'b0;
      end else if (psel && !ready_q) begin
        ready_q <= 1'b1;
        prdata_q <= pwrite ? 32'h00000000 : rd_d;
        pslverr_q <= rd_err;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= '0;
      io_cfg_q <= IO_CFG_RST;
    end else if (wr_en) begin
      if (paddr == OFF_SEL) begin
        sel_q <= pwdata[SW-1:0];
      end
      if (paddr == OFF_IO_CFG) begin
        io_cfg_q <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N_TOT; i++) begin
        lut_q[i] <= LUT_RST;
        cfg_q[i] <= CFG_RST;
      end
    end else if (wr_en && sel_ok) begin
      if (paddr == OFF_LUT) begin
        lut_q[sel_q] <= pwdata[LUT_BITS-1:0];
      end
      if (paddr == OFF_CFG) begin
        cfg_q[sel_q] <= pwdata[CFG_BITS-1:0];
      end
    end
  end

  // ****************
  // elements
  // ****************
  // cluster of twelve logic and twelve interface elements
  for (genvar i = 0; i < N_TOT; i++) begin : g_elem
    logic [LUT_INPUTS-1:0] idx;
    logic d_mux;
    assign idx = all_in[LUT_INPUTS*i +: LUT_INPUTS];
    assign all_y[i] = lut_q[i][idx];
    assign d_mux = cfg_q[i][CFG_DSEL] ? all_y[i] : all_direct[i];
    fle_storage u_store (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .ce(all_ce[i]),
      .d(d_mux),
      .aload(all_aload[i]),
      .sload(all_sload[i]),
      .latch_mode(cfg_q[i][CFG_LATCH]),
      .aload_val(cfg_q[i][CFG_AVAL]),
      .sload_val(cfg_q[i][CFG_SVAL]),
      .q(all_q[i])
    );
  end

  // ****************
  // carry chain
  // ****************
  // generate is taken from the first two table inputs, propagate from
  // the table result; N_LE must be a multiple of the segment length
  assign carry[0] = le_cin;
  assign le_cout = carry[N_LE];
  for (genvar i = 0; i < N_LE; i++) begin : g_gen
    assign gen[i] = le_in[LUT_INPUTS*i] & le_in[LUT_INPUTS*i+1];
    assign le_sum[i] = le_y[i] ^ carry[i];
  end
  for (genvar s = 0; s < N_SEG; s++) begin : g_seg
    localparam int B = s * CARRY_SEG;
    logic [2:0] p;
    logic [2:0] g;
    assign p = le_y[B +: 3];
    assign g = gen[B +: 3];
    assign carry[B+1] = g[0] | (p[0] & carry[B]);
    assign carry[B+2] = g[1] | (p[1] & g[0]) | (p[1] & p[0] & carry[B]);
    assign carry[B+3] = g[2] | (p[2] & g[1]) | (p[2] & p[1] & g[0]) |
                        (p[2] & p[1] & p[0] & carry[B]);
  end

  // ****************
  // pad digital section
  // ****************
  logic [IO_W-1:0] out_q;
  logic [IO_W-1:0] oe_q;
  logic [IO_W-1:0] in_s1_q;
  logic [IO_W-1:0] in_s2_q;
  logic [IO_W-1:0] in_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
      oe_q <= '0;
    end else if (clk_en) begin
      out_q <= io_out_data;
      oe_q <= io_oe_data;
    end
  end

  assign pad_out = io_cfg_q[IO_OUT_REG] ? out_q : io_out_data;
  assign pad_oe = io_cfg_q[IO_OE_REG] ? oe_q : io_oe_data;

  // pad input synchroniser
  // pads are asynchronous, so two stages are kept even when the
  // optional input register is off; it only adds a third stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
      in_q <= '0;
    end else if (clk_en) begin
      in_s1_q <= pad_in;
      in_s2_q <= in_s1_q;
      in_q <= in_s2_q;
    end
  end
  assign io_in_data = io_cfg_q[IO_IN_REG] ? in_q : in_s2_q;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [N_LE:0] ref_c;
  always_comb begin
    ref_c[0] = le_cin;
    for (int i = 0; i < N_LE; i++) begin
      ref_c[i+1] = gen[i] | (le_y[i] & ref_c[i]);
    end
  end

  lut_lookup_a: assert property (
    le_y[0] == lut_q[0][le_in[3:0]])
    else $error("table output does not follow its mask");
  sum_xor_a: assert property (
    le_sum == (le_y ^ ref_c[N_LE-1:0]))
    else $error("sum is not table xor carry");
  carry_chain_a: assert property (
    le_cout == ref_c[N_LE] && carry[1] == ref_c[1])
    else $error("carry chain disagrees with ripple reference");
  ce_hold_a: assert property (
    clk_en && !le_ce[0] && !le_async_preload[0] && !cfg_q[0][CFG_LATCH]
    |=> $stable(le_q[0]) || le_async_preload[0])
    else $error("storage changed with enable low");
  aload_force_a: assert property (
    le_async_preload[0] |-> le_q[0] == cfg_q[0][CFG_AVAL])
    else $error("async load did not force the value");
  sload_edge_a: assert property (
    clk_en && le_ce[0] && le_clocked_preload[0] && !le_async_preload[0]
    && !cfg_q[0][CFG_LATCH] ##1 !le_async_preload[0] && !wr_en
    |-> le_q[0] == $past(cfg_q[0][CFG_SVAL]))
    else $error("sync load value not stored");
  dsel_path_a: assert property (
    clk_en && ie_ce[0] && !ie_clocked_preload[0] && !ie_async_preload[0]
    && !cfg_q[N_LE][CFG_LATCH] && !wr_en ##1 !ie_async_preload[0]
    |-> ie_q[0] == $past(cfg_q[N_LE][CFG_DSEL] ? ie_y[0] : ie_direct_in[0]))
    else $error("storage data source wrong");
  latch_pass_a: assert property (
    clk_en && le_ce[0] && cfg_q[0][CFG_LATCH] && !le_async_preload[0]
    |-> le_q[0] == (cfg_q[0][CFG_DSEL] ? le_y[0] : le_direct_in[0]))
    else $error("latch not transparent");
  pad_out_a: assert property (
    clk_en && io_cfg_q[IO_OUT_REG] ##1 io_cfg_q[IO_OUT_REG]
    |-> pad_out == $past(io_out_data))
    else $error("registered pad output wrong");
  pad_oe_a: assert property (
    clk_en && io_cfg_q[IO_OE_REG] ##1 io_cfg_q[IO_OE_REG]
    |-> pad_oe == $past(io_oe_data))
    else $error("registered output enable wrong");
  // the stages hold zero in reset, so count only cycles out of it
  in_sync_a: assert property (
    (presetn && clk_en && !io_cfg_q[IO_IN_REG])[*3]
    |-> io_in_data == $past(pad_in, 2))
    else $error("pad input not two stages late");

  aload_seen_c: cover property (le_async_preload[0] ##1 !le_async_preload[0]);
  carry_out_c: cover property (le_cin && le_cout);
  apb_write_c: cover property (wr_en && paddr == OFF_LUT);
  latch_used_c: cover property (cfg_q[0][CFG_LATCH] && le_ce[0]);
endmodule
`default_nettype wire

// File: hw/fle_pkg.sv
`default_nettype none
package fle_pkg;
  // ****************
  // sizes
  // ****************
  localparam int LE_PER_CLUSTER = 12;
  localparam int IE_PER_CLUSTER = 12;
  // a hard block is spanned by three interface clusters
  localparam int IE_PER_HARD_BLOCK = 36;
  localparam int CARRY_SEG = 3;
  localparam int LUT_INPUTS = 4;
  localparam int LUT_BITS = 16;
  localparam int CFG_BITS = 4;
  localparam int IO_WIDTH = 4;
  localparam int ADDR_W = 8;
  // ****************
  // register offsets
  // ****************
  localparam logic [7:0] OFF_SEL = 8'h00;
  localparam logic [7:0] OFF_LUT = 8'h04;
  localparam logic [7:0] OFF_CFG = 8'h08;
  localparam logic [7:0] OFF_LE_Q = 8'h0C;
  localparam logic [7:0] OFF_IE_Q = 8'h10;
  localparam logic [7:0] OFF_IO_CFG = 8'h14;
  localparam logic [7:0] OFF_IO_IN = 8'h18;
  // ****************
  // field positions
  // ****************
  localparam int CFG_LATCH = 0;
  localparam int CFG_DSEL = 1;
  localparam int CFG_AVAL = 2;
  localparam int CFG_SVAL = 3;
  localparam int IO_OUT_REG = 0;
  localparam int IO_OE_REG = 1;
  localparam int IO_IN_REG = 2;
  // ****************
  // reset values
  // ****************
  localparam logic [15:0] LUT_RST = 16'h0000;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [2:0] IO_CFG_RST = 3'h0;
endpackage
`default_nettype wire

// File: hw/fle_storage.sv
`default_nettype none
module fle_storage
  import fle_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic ce,
  input wire logic d,
  input wire logic aload,
  input wire logic sload,
  input wire logic latch_mode,
  input wire logic aload_val,
  input wire logic sload_val,
  output logic q
);
  logic q_q;

  // async load override
  // the override is combinational so it shows at once, not at an edge
  always_comb begin
    if (aload) begin
      q = aload_val;
    end else if (latch_mode && ce && clk_en) begin
      q = d;
    end else begin
      q = q_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_q <= 1'b0;
    end else if (clk_en) begin
      if (aload) begin
        q_q <= aload_val;
      end else if (ce) begin
        if (sload) begin
          q_q <= sload_val;
        end else begin
          q_q <= d;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/pad_loop_model.sv
`default_nettype none
// ****************
// pad wiring seen from the fabric side
// ****************
module pad_loop_model
  import fle_pkg::*;
(
  input wire logic pclk,
  input wire logic [IO_WIDTH-1:0] pad_out,
  input wire logic [IO_WIDTH-1:0] pad_oe,
  output logic [IO_WIDTH-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [IO_WIDTH-1:0] last_q;
  always_ff @(posedge pclk) begin
    for (int i = 0; i < IO_WIDTH; i++) begin
      if (pad_oe[i]) begin
        last_q[i] <= pad_out[i];
      end
    end
  end
  // an undriven pad must not read back as a stale, valid-looking level
  always_comb begin
    for (int i = 0; i < IO_WIDTH; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ~last_q[i];
    end
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
module testbench
  import fle_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MASK = 16'h6A93;
  logic pclk = 0, presetn = 0, clk_en = 1, le_cin = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, le_cout;
  logic [47:0] le_in = '0, ie_in = '0;
  logic [11:0] le_direct_in = '0, le_ce = '0, le_y, le_sum, le_q;
  logic [11:0] le_async_preload = '0, le_clocked_preload = '0;
  logic [11:0] ie_direct_in = '0, ie_ce = '0, ie_y, ie_q;
  logic [11:0] ie_async_preload = '0, ie_clocked_preload = '0;
  logic [3:0] io_out_data = 4'hA, io_oe_data = 4'hF;
  logic [3:0] io_in_data, pad_in, pad_out, pad_oe;
  int n_fail = 0;
  int cmp_count = 0;

  fabric_logic_element dut (
    .pclk, .presetn, .clk_en, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .le_in, .le_direct_in,
    .le_ce, .le_async_preload, .le_clocked_preload, .le_cin,
    .le_cout, .le_y, .le_sum, .le_q, .ie_in, .ie_direct_in, .ie_ce,
    .ie_async_preload, .ie_clocked_preload, .ie_y, .ie_q,
    .io_out_data, .io_oe_data, .io_in_data, .pad_in, .pad_out, .pad_oe
  );
  pad_loop_model u_pad (.pclk, .pad_out, .pad_oe, .pad_in);

  always #2 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      n_fail++;
    end
  endtask

  // ****************
  // apb master: hold everything until pready is sampled high
  // ****************
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, e, input logic ee);
    logic [31:0] r;
    logic er;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog bounds this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 1, 32'(pready));
    chk("pslverr", 32'(ee), 32'(er));
    if (!w && !ee) chk("prdata", e, r);
  endtask

  task automatic smp;
    @(posedge pclk);
    #1;
  endtask

  task automatic done_t(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    acc(0, OFF_LUT, 0, 0, 0);
    acc(0, OFF_CFG, 0, 0, 0);
    acc(0, OFF_IO_CFG, 0, 0, 0);
    acc(1, 8'h1C, 32'h1, 0, 1);
    acc(0, 8'h1C, 0, 0, 1);
    acc(1, OFF_LE_Q, 32'hF, 0, 1);
    done_t("reset");
    acc(1, OFF_LUT, {16'h0, MASK}, 0, 0);
    acc(0, OFF_LUT, 0, {16'h0, MASK}, 0);
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk);
      le_in[3:0] <= 4'(i);
      le_cin <= ~i[0];
      #1;
      chk("le_y", 32'(MASK[i]), 32'(le_y[0]));
      chk("le_sum", 32'(MASK[i] ^ le_cin), 32'(le_sum[0]));
    end
    done_t("table");
    @(posedge pclk);
    le_direct_in[0] <= 1'b1;
    smp;
    chk("q_ce_low", 0, 32'(le_q[0]));
    @(posedge pclk);
    le_ce[0] <= 1'b1;
    smp;
    chk("q_ce_high", 1, 32'(le_q[0]));
    @(posedge pclk);
    le_clocked_preload[0] <= 1'b1;
    #1;
    chk("q_sload_wait", 1, 32'(le_q[0]));
    smp;
    chk("q_sload", 0, 32'(le_q[0]));
    @(posedge pclk);
    le_direct_in[0] <= 1'b0;
    acc(1, OFF_CFG, 32'h4, 0, 0);
    @(posedge pclk);
    le_async_preload[0] <= 1'b1;
    #1;
    chk("q_aload", 1, 32'(le_q[0]));
    smp;
    chk("q_aload_hold", 1, 32'(le_q[0]));
    @(posedge pclk);
    le_async_preload[0] <= 1'b0;
    le_clocked_preload[0] <= 1'b0;
    acc(1, OFF_CFG, 32'h1, 0, 0);
    @(posedge pclk);
    le_direct_in[0] <= 1'b1;
    le_in[3:0] <= 4'h0;
    #1;
    chk("q_latch", 1, 32'(le_q[0]));
    acc(0, OFF_LE_Q, 0, 32'h1, 0);
    acc(1, OFF_LUT, 32'h8000, 0, 0);
    acc(1, OFF_CFG, 32'h2, 0, 0);
    @(posedge pclk);
    le_direct_in[0] <= 1'b0;
    le_in[3:0] <= 4'hF;
    #1;
    chk("q_table_pre", 0, 32'(le_q[0]));
    smp;
    chk("q_table", 1, 32'(le_q[0]));
    @(posedge pclk);
    clk_en <= 1'b0;
    le_in[3:0] <= 4'h0;
    smp;
    chk("q_frozen", 1, 32'(le_q[0]));
    @(posedge pclk);
    clk_en <= 1'b1;
    smp;
    chk("q_thawed", 0, 32'(le_q[0]));
    done_t("storage");
    for (int i = 0; i < 12; i++) begin
      acc(1, OFF_SEL, 32'(i), 0, 0);
      acc(1, OFF_LUT, 32'hFFFF, 0, 0);
    end
    for (int c = 0; c < 3; c++) begin
      @(posedge pclk);
      le_in <= (c == 2) ? 48'h3 << 44 : 48'h0;
      le_cin <= (c == 1);
      #1;
      chk("cout", 32'(c != 0), 32'(le_cout));
      chk("sum", (c == 1) ? 0 : 32'hFFF, 32'(le_sum));
    end
    done_t("carry");
    acc(1, OFF_SEL, 32'd12, 0, 0);
    acc(1, OFF_LUT, 32'h1, 0, 0);
    acc(1, OFF_CFG, 32'h0, 0, 0);
    @(posedge pclk);
    ie_direct_in[0] <= 1'b1;
    ie_ce[0] <= 1'b1;
    smp;
    chk("ie_y", 32'h1, 32'(ie_y));
    acc(0, OFF_IE_Q, 0, 32'h1, 0);
    acc(1, OFF_SEL, 32'd24, 0, 0);
    acc(1, OFF_LUT, 32'h5, 0, 1);
    acc(0, OFF_CFG, 0, 0, 1);
    chk("le_count", LE_PER_CLUSTER, 32'($bits(le_y)));
    chk("ie_count", IE_PER_CLUSTER, 32'($bits(ie_y)));
    done_t("interface");
    chk("pad_thru", 32'hA, 32'(pad_out));
    for (int n = 2; n < 4; n++) begin
      acc(1, OFF_IO_CFG, (n == 3) ? 32'h4 : 32'h0, 0, 0);
      @(posedge pclk);
      io_out_data <= 4'(n + 4);
      repeat (n - 1) smp;
      chk("in_early", (n == 2) ? 32'hA : 32'h6, 32'(io_in_data));
      smp;
      chk("in_sync", 32'(n + 4), 32'(io_in_data));
    end
    acc(0, OFF_IO_IN, 0, 32'h7, 0);
    acc(1, OFF_IO_CFG, 32'h3, 0, 0);
    @(posedge pclk);
    io_out_data <= 4'h5;
    io_oe_data <= 4'h3;
    #1;
    chk("pad_reg_old", 32'hF7, 32'({pad_oe, pad_out}));
    smp;
    chk("pad_reg", 32'h35, 32'({pad_oe, pad_out}));
    done_t("pads");
    conclude();
  end
endmodule
`default_nettype wire
